// [core/reb_pkg.sv]
// Shared constants and types for the repeater expansion bus
package reb_pkg;
  // Clock rate and bit time
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned BIT_TIME_NS = 100;
  // Least time: round up to whole cycles
  localparam int unsigned BIT_TIME_CYC = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] BIT_TIME_CNT = CNT_W'(BIT_TIME_CYC);
  // Chain input levels at reset release that select the external-arbiter mode
  localparam logic [1:0] EXT_MODE_CODE_DEF = 2'h0;
  // Reset values
  localparam logic RESET_MODE_EXT = 1'b0;
  localparam logic [CNT_W-1:0] RESET_CNT = 5'h00;

  // Bus-sharing modes
  typedef enum logic {REB_MODE_CHAIN, REB_MODE_EXT} reb_mode_e;
endpackage

// [core/reb_bus_if.sv]
// Expansion bus wires joining a repeater device and its far party
`timescale 1ns/1ps
interface reb_bus_if;
  // Chain request levels, active low
  logic [1:0] chain_request_in_n;
  logic chain_request_out_n;
  // Shared activity line: device and far-party drives
  logic act_n_dev_o;
  logic act_n_dev_oe;
  logic act_n_far_o;
  logic act_n_far_oe;
  logic act_n;
  // Shared collision line
  logic col_n_dev_o;
  logic col_n_dev_oe;
  logic col_n_far_o;
  logic col_n_far_oe;
  logic col_n;
  // Repeated data and internal collision from device
  logic repeated_data_o;
  logic repeated_data_oe;
  logic internal_collision_o;
  logic internal_collision_oe;

  // Wire levels: pulled high, any low driver wins
  assign act_n = !((act_n_dev_oe && !act_n_dev_o) || (act_n_far_oe && !act_n_far_o));
  assign col_n = !((col_n_dev_oe && !col_n_dev_o) || (col_n_far_oe && !col_n_far_o));

  modport dev (
    input chain_request_in_n,
    output chain_request_out_n,
    output act_n_dev_o,
    output act_n_dev_oe,
    input act_n,
    output col_n_dev_o,
    output col_n_dev_oe,
    input col_n,
    output repeated_data_o,
    output repeated_data_oe,
    output internal_collision_o,
    output internal_collision_oe
  );
  modport far (
    output chain_request_in_n,
    input chain_request_out_n,
    output act_n_far_o,
    output act_n_far_oe,
    input act_n,
    output col_n_far_o,
    output col_n_far_oe,
    input col_n,
    input repeated_data_o,
    input repeated_data_oe,
    input internal_collision_o,
    input internal_collision_oe
  );
endinterface

// [core/reb_device.sv]
// Repeater-side expansion bus end: mode latch, chain arbitration, data drive
`timescale 1ns/1ps
module reb_device
  import reb_pkg::*;
#(
  parameter logic [1:0] EXT_MODE_CODE = EXT_MODE_CODE_DEF
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus side
  reb_bus_if.dev bus,
  // Repeater core side
  input wire logic port_active,
  input wire logic rx_data,
  input wire logic port_collision,
  input wire logic multiport_collision,
  output logic mode_ext,
  output logic bus_act_seen,
  output logic bus_col_seen
);
  // Two-flop synchronisers for pins from outside
  logic [1:0] req_s1_q, req_s2_q;
  logic act_s1_q, act_s2_q, col_s1_q, col_s2_q;
  logic rst_seen_q;
  logic mode_ext_q;
  logic [CNT_W-1:0] wait_q;
  logic [CNT_W-1:0] wait_d;
  logic data_q, jam_q, req_q, act_q, col_q, drive_q;

  // Synchronise chain inputs and shared lines before use
  always_ff @(posedge sys_clk)
  begin
    req_s1_q <= bus.chain_request_in_n;
    req_s2_q <= req_s1_q;
    act_s1_q <= bus.act_n;
    act_s2_q <= act_s1_q;
    col_s1_q <= bus.col_n;
    col_s2_q <= col_s1_q;
  end

  // Mode caught at first edge after release; strap is not captured in reset
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rst_seen_q <= 1'b0;
      mode_ext_q <= RESET_MODE_EXT;
    end
    else if (!rst_seen_q)
    begin
      rst_seen_q <= 1'b1;
      mode_ext_q <= (req_s2_q == EXT_MODE_CODE);
    end
  end

  // Chain decode; unconnected inputs rely on system pull-ups
  wire any_req_low = !req_s2_q[0] || !req_s2_q[1];
  wire both_req_low = !req_s2_q[0] && !req_s2_q[1];
  wire chain_req = port_active || any_req_low;
  wire chain_col = (port_active && any_req_low) || both_req_low;
  wire chain_act = port_active && !chain_col && col_s2_q;
  // External arbiter drives the lines; grant is activity low
  wire ext_grant = port_active && !act_s2_q;
  wire chain_grant = port_active && !chain_col && (wait_q == BIT_TIME_CNT);
  wire drive_d = mode_ext_q ? ext_grant : chain_grant;
  wire req_d = mode_ext_q ? port_active : chain_req;
  wire jam_d = port_collision;
  // Collision carries type on data line
  wire data_d = port_collision ? !multiport_collision : rx_data;

  // Bit-time wait after request goes low
  always_comb
  begin
    wait_d = RESET_CNT;
    if (!mode_ext_q && port_active)
      wait_d = (wait_q == BIT_TIME_CNT) ? wait_q : CNT_W'(wait_q + 1'b1);
  end

  // Registered bus outputs, clock-synchronous
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wait_q <= RESET_CNT;
      data_q <= 1'b0;
      jam_q <= 1'b0;
      req_q <= 1'b0;
      act_q <= 1'b0;
      col_q <= 1'b0;
      drive_q <= 1'b0;
    end
    else
    begin
      wait_q <= wait_d;
      data_q <= data_d;
      jam_q <= jam_d;
      req_q <= rst_seen_q && req_d;
      act_q <= rst_seen_q && !mode_ext_q && chain_act;
      col_q <= rst_seen_q && !mode_ext_q && chain_col;
      drive_q <= rst_seen_q && drive_d;
    end
  end

  // Open-drain lines only pull low; released otherwise
  assign bus.chain_request_out_n = !req_q;
  assign bus.act_n_dev_o = 1'b0;
  assign bus.act_n_dev_oe = act_q;
  assign bus.col_n_dev_o = 1'b0;
  assign bus.col_n_dev_oe = col_q;
  assign bus.repeated_data_o = data_q;
  assign bus.repeated_data_oe = drive_q;
  assign bus.internal_collision_o = jam_q;
  assign bus.internal_collision_oe = drive_q;
  // Status toward core
  assign mode_ext = mode_ext_q;
  assign bus_act_seen = !act_s2_q;
  assign bus_col_seen = !col_s2_q;
endmodule

// [core/reb_arbiter.sv]
// Far-end party: external arbiter plus chain input straps
`timescale 1ns/1ps
module reb_arbiter
  import reb_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus side
  reb_bus_if.far bus,
  // User side
  input wire logic [1:0] strap_req_n,
  input wire logic arbiter_en,
  input wire logic other_request,
  output logic grant_seen
);
  logic req_s1_q, req_s2_q;
  logic act_q, col_q;

  // Synchronise device request
  always_ff @(posedge sys_clk)
  begin
    req_s1_q <= bus.chain_request_out_n;
    req_s2_q <= req_s1_q;
  end

  wire dev_req = !req_s2_q;
  wire one_req = dev_req ^ other_request;
  wire many_req = dev_req && other_request;

  // Grant only the device, and only when it requests alone; withdraw all on contention
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      act_q <= 1'b0;
      col_q <= 1'b0;
    end
    else
    begin
      act_q <= arbiter_en && one_req && dev_req;
      col_q <= arbiter_en && many_req;
    end
  end

  // Straps hold unused chain inputs high
  assign bus.chain_request_in_n = strap_req_n;
  assign bus.act_n_far_o = 1'b0;
  assign bus.act_n_far_oe = act_q;
  assign bus.col_n_far_o = 1'b0;
  assign bus.col_n_far_oe = col_q;
  assign grant_seen = bus.repeated_data_oe;
endmodule

// [tb/reb_bus_sva.sv]
// Checker for the expansion bus wires between device and arbiter ends
`timescale 1ns/1ps
module reb_bus_sva
  import reb_pkg::*;
#(
  parameter logic [1:0] EXT_MODE_CODE = EXT_MODE_CODE_DEF
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Watched wires
  input wire logic [1:0] chain_request_in_n,
  input wire logic chain_request_out_n,
  input wire logic act_n_dev_o,
  input wire logic act_n_dev_oe,
  input wire logic col_n_dev_oe,
  input wire logic act_n,
  input wire logic col_n,
  input wire logic repeated_data_oe,
  input wire logic internal_collision_oe
);
  // Lower bound allows one cycle of request launch latency
  localparam int WAIT_MIN = 12;
  logic ext_q;
  logic [4:0] low_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Mode copy taken while reset holds the straps
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n) ext_q <= (chain_request_in_n == EXT_MODE_CODE);
  end
  // Cycles the request has stood low, saturating
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || chain_request_out_n) low_q <= 5'h00;
    else if (low_q != 5'h1F) low_q <= low_q + 5'h01;
  end
  // Chain inputs held long enough to pass the synchronizer
  sequence ins_held(logic [1:0] v);
    (!ext_q && chain_request_in_n == v) [*4];
  endsequence
  req_follow_a: assert property (ins_held(2'h2) |=> !chain_request_out_n) else $error("req");
  act_kind_a: assert property (act_n_dev_oe |-> !act_n_dev_o && !ext_q) else $error("act");
  col_pair_a: assert property (ins_held(2'h0) |=> col_n_dev_oe) else $error("col pair");
  col_idle_a: assert property (ins_held(2'h3) |=> !col_n_dev_oe) else $error("col idle");
  col_wins_a: assert property ((!col_n) [*4] |=> !act_n_dev_oe) else $error("col excl");
  bit_wait_a: assert property (!ext_q && $rose(repeated_data_oe) |-> low_q >= WAIT_MIN)
    else $error("data early");
  data_rel_a: assert property ((!ext_q && chain_request_out_n) [*2] |=> !repeated_data_oe)
    else $error("data held");
  ext_hiz_a: assert property ((ext_q && act_n) [*4] |=> !repeated_data_oe && !internal_collision_oe)
    else $error("not hiz");
endmodule

// [tb/repeater_expansion_bus_tb.sv]
// Bench joining a repeater end to the arbiter end
`timescale 1ns/1ps
module repeater_expansion_bus_tb;
  logic sys_clk, rst_n, port_active, rx_data, port_collision, multiport_collision;
  logic mode_ext, bus_act_seen, bus_col_seen, arbiter_en, other_request, grant_seen;
  logic [1:0] strap_req_n;
  int failures, n_compared, cyc_cnt;
  reb_bus_if bus();
  // Both ends face each other across one interface
  reb_device reb_device_i (.sys_clk, .rst_n, .bus(bus), .port_active, .rx_data,
    .port_collision, .multiport_collision, .mode_ext, .bus_act_seen, .bus_col_seen);
  reb_arbiter reb_arbiter_i (.sys_clk, .rst_n, .bus(bus), .strap_req_n, .arbiter_en,
    .other_request, .grant_seen);
  reb_bus_sva reb_bus_sva_i (.sys_clk, .rst_n, .chain_request_in_n(bus.chain_request_in_n),
    .chain_request_out_n(bus.chain_request_out_n), .act_n_dev_o(bus.act_n_dev_o),
    .act_n_dev_oe(bus.act_n_dev_oe), .col_n_dev_oe(bus.col_n_dev_oe), .act_n(bus.act_n),
    .col_n(bus.col_n), .repeated_data_oe(bus.repeated_data_oe),
    .internal_collision_oe(bus.internal_collision_oe));
  // Clock source
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic conclude;
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard, far above the roughly 80 cycles needed
  always @(posedge sys_clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 1000)
    begin
      failures++;
      conclude();
    end
  end
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Straps stay put across release so the mode latch sees them
  task automatic do_reset(input logic [1:0] s, input logic en);
    rst_n = 1'b0;
    strap_req_n = s;
    arbiter_en = en;
    cyc(2);
    rst_n = 1'b1;
    cyc(1);
  endtask
  task automatic t_chain;
    chk(mode_ext, 1'b0);
    port_active = 1'b1;
    cyc(2);
    chk(bus.chain_request_out_n, 1'b0);
    chk(bus.act_n, 1'b0);
    cyc(reb_pkg::BIT_TIME_CNT - 4);
    chk(bus.repeated_data_oe, 1'b0);
    chk(bus_act_seen, 1'b1);
    cyc(6);
    chk(bus.repeated_data_oe, 1'b1);
    rx_data = 1'b1;
    cyc(2);
    chk(bus.repeated_data_o, 1'b1);
    rx_data = 1'b0;
    cyc(2);
    chk(bus.repeated_data_o, 1'b0);
    port_collision = 1'b1;
    cyc(2);
    chk({bus.internal_collision_o, bus.repeated_data_o}, 2'h3);
    multiport_collision = 1'b1;
    cyc(2);
    chk({bus.internal_collision_o, bus.repeated_data_o}, 2'h2);
    port_collision = 1'b0;
    multiport_collision = 1'b0;
  endtask
  task automatic t_cascade;
    strap_req_n = 2'h2;
    cyc(5);
    chk({bus.col_n, bus.act_n}, 2'h1);
    chk(bus_col_seen, 1'b1);
    port_active = 1'b0;
    cyc(5);
    chk({bus.col_n, bus.chain_request_out_n}, 2'h2);
    strap_req_n = 2'h0;
    cyc(5);
    chk(bus.col_n, 1'b0);
    strap_req_n = 2'h3;
    cyc(5);
    chk({bus.chain_request_out_n, bus.act_n, bus.col_n, bus.repeated_data_oe}, 4'hE);
  endtask
  task automatic t_ext;
    do_reset(2'h0, 1'b1);
    chk(mode_ext, 1'b1);
    cyc(4);
    chk({bus.chain_request_out_n, bus.repeated_data_oe}, 2'h2);
    port_active = 1'b1;
    cyc(2);
    chk(bus.chain_request_out_n, 1'b0);
    cyc(8);
    chk({bus.act_n, grant_seen}, 2'h1);
    other_request = 1'b1;
    cyc(8);
    chk({bus.act_n, bus.col_n, grant_seen}, 3'h4);
    other_request = 1'b0;
    port_active = 1'b0;
    cyc(8);
    chk(bus.repeated_data_oe, 1'b0);
  endtask
  // Main sequence, inputs moved on falling edges only
  initial
  begin
    {port_active, rx_data, port_collision, multiport_collision, other_request} = 5'h00;
    {failures, n_compared, cyc_cnt} = '0;
    do_reset(2'h3, 1'b0);
    t_chain();
    t_cascade();
    t_ext();
    conclude();
  end
endmodule
